// [rtl/pdw_pkg.sv]
// Purpose: shared constants for the communication supervision block
// Assumes: 100 MHz system clock, millisecond time base
// Notes: rule summary follows
// Contract
// - net lamp green when connection present
// - net lamp flashes yellow during address requests
// - net lamp steady yellow on invalid IP
// - net lamp red on static duplicate IP
// - net lamp red on supervision error
// - supply lamps follow supply state
// - io lamps show set or fault
// - io lamps indexed byte then bit
// - watchdog off with zero timeout at reset
// - expiry blocks outputs, applies substitute
// - writes stored during fail, used after
// - first write starts, later writes restart
// - reads never touch the watchdog
// - expiry sets status bit 1, lamp red
// - running watchdog cannot be stopped
// - substitute held until acknowledged
// - acknowledge restarts the watchdog
// - timeout 200..65000 ms or zero
// - auto or manual acknowledge mode
// - auto mode: next write acknowledges
// - manual mode: command acknowledges only (code also takes web_ack)
// - substitute codes zero, one, hold
// - command needs exactly one set bit
// - watchdog fail reason code 000C
package pdw_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned BLINK_MS = 500;
    localparam logic [15:0] TMO_MIN = 16'h00C8;
    localparam logic [15:0] TMO_MAX = 16'hFDE8;
    localparam logic [15:0] TMO_RST = 16'h0000;
    localparam logic [15:0] SUB_ZERO = 16'h0000;
    localparam logic [15:0] SUB_ONE = 16'h0001;
    localparam logic [15:0] SUB_HOLD = 16'h0002;
    localparam logic [15:0] CMD_SET_FAIL = 16'h0010;
    localparam logic [15:0] CMD_ACK_FAIL = 16'h0020;
    localparam logic [15:0] RSN_NONE = 16'h0000;
    localparam logic [15:0] RSN_USER = 16'h0009;
    localparam logic [15:0] RSN_WDOG = 16'h000C;
    localparam logic [15:0] RSN_CONN = 16'h000D;
    localparam int unsigned STAT_FAIL_BIT = 1;
    localparam logic [1:0] LAMP_OFF = 2'h0;
    localparam logic [1:0] LAMP_GREEN = 2'h1;
    localparam logic [1:0] LAMP_YELLOW = 2'h2;
    localparam logic [1:0] LAMP_RED = 2'h3;
    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_ARMED = 2'b01,
        WD_RUN = 2'b11,
        WD_FAIL = 2'b10
    } pdw_wd_state_t;
endpackage

// [rtl/pdw_tick.sv]
// Purpose: one-cycle enable pulse every period of CYC clocks
// Assumes: CYC at least 2
// Notes: free running from reset
`timescale 1ns/1ps
module pdw_tick #(
    parameter int unsigned CYC = 100_000
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    output logic tick_q
);
    logic [31:0] cnt_q; // cycles in current period

    initial begin
        if (CYC < 2) $error("pdw_tick: CYC too small");
    end

    // count up, pulse on wrap
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(CYC - 1)) begin
            cnt_q <= 32'h0000_0000;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end
endmodule

// [rtl/pdw_lamps.sv]
// Purpose: per-channel input/output indicator drive
// Assumes: same clock domain as the supervisor
// Notes: output lamp code per channel uses the package colour codes; input lamps are one bit each
`timescale 1ns/1ps
module pdw_lamps #(
    parameter int unsigned NCH = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [NCH-1:0] in_state,
    input wire logic [NCH-1:0] out_state,
    input wire logic [NCH-1:0] out_fault,
    output logic [NCH-1:0] in_lamp_q,
    output logic [2*NCH-1:0] out_lamp_q
);
    initial begin
        if (NCH < 1 || NCH > 8) $error("pdw_lamps: NCH out of range");
    end

    // lamp index i is byte 0 bit i, so label "0i"
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_lamp_q <= '0;
            out_lamp_q <= '0;
        end else begin
            in_lamp_q <= in_state;
            for (int i = 0; i < NCH; i++) begin
                // fault wins over plain set
                if (out_fault[i])
                    out_lamp_q[2*i +: 2] <= pdw_pkg::LAMP_RED;
                else if (out_state[i])
                    out_lamp_q[2*i +: 2] <= pdw_pkg::LAMP_YELLOW;
                else
                    out_lamp_q[2*i +: 2] <= pdw_pkg::LAMP_OFF;
            end
        end
    end
endmodule

// [rtl/pdw_top.sv]
// Purpose: process data watchdog, communication-loss state and lamps
// Assumes: protocol engine delivers decoded one-cycle write/read strobes
// Notes: network, supply and I/O pins are synchronised; controls are not
`timescale 1ns/1ps
module pdw_top #(
    parameter int unsigned NCH = 8,
    parameter int unsigned TICK_CYC = pdw_pkg::TICK_CYC,
    parameter int unsigned BLINK_MS = pdw_pkg::BLINK_MS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // process data side (same domain, one-cycle strobes)
    input wire logic out_wr,
    input wire logic [NCH-1:0] out_wr_data,
    input wire logic out_rd,
    input wire logic tmo_wr,
    input wire logic [15:0] tmo_wr_data,
    input wire logic sub_wr,
    input wire logic [15:0] sub_wr_data,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wr_data,
    input wire logic web_ack,
    input wire logic manual_ack_mode,
    input wire logic conn_timeout,
    // network status levels (pins)
    input wire logic conn_up,
    input wire logic addr_req_active,
    input wire logic ip_invalid,
    input wire logic static_dup_ip,
    // supply and I/O pins
    input wire logic sens_ok,
    input wire logic sens_overload,
    input wire logic act_ok,
    input wire logic [NCH-1:0] in_pins,
    input wire logic [NCH-1:0] out_fault_pins,
    // results
    output logic [NCH-1:0] out_drive_q,
    output logic [NCH-1:0] out_store_q,
    output logic [15:0] tmo_q,
    output logic [15:0] sub_mode_q,
    output logic [15:0] fail_reason_q,
    output logic [15:0] status_q,
    output logic net_fail_q,
    output logic cmd_err_q,
    output logic tmo_err_q,
    output logic [1:0] net_lamp_q,
    output logic [1:0] sensor_supply_lamp_q,
    output logic actuator_supply_lamp_q,
    output logic [NCH-1:0] in_lamp_q,
    output logic [2*NCH-1:0] out_lamp_q
);
    ////////////////////////////////////////////////////////////////////
    // checks and helpers

    initial begin
        if (NCH < 1 || NCH > 8) $error("pdw_top: NCH out of range");
        if (TICK_CYC < 2) $error("pdw_top: TICK_CYC too small");
        if (BLINK_MS < 1) $error("pdw_top: BLINK_MS too small");
    end

    // exactly one bit set in a command word
    function automatic logic one_hot16(input logic [15:0] v);
        return (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
    endfunction

    // accepted timeout: zero or inside the window
    function automatic logic tmo_ok(input logic [15:0] v);
        return (v == 16'h0000) ||
               (v >= pdw_pkg::TMO_MIN && v <= pdw_pkg::TMO_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers (two flops, first read only by second)

    localparam int unsigned SW = 7 + 2 * NCH;
    logic [SW-1:0] sy1_q; // first stage
    logic [SW-1:0] sy2_q; // second stage, safe to use
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {conn_up, addr_req_active, ip_invalid, static_dup_ip,
                      sens_ok, sens_overload, act_ok, in_pins,
                      out_fault_pins};
            sy2_q <= sy1_q;
        end
    end
    logic s_conn, s_addr, s_ipbad, s_dup, s_sens, s_sovl, s_act;
    logic [NCH-1:0] s_in, s_oflt;
    assign {s_conn, s_addr, s_ipbad, s_dup, s_sens, s_sovl, s_act, s_in,
            s_oflt} = sy2_q;

    ////////////////////////////////////////////////////////////////////
    // millisecond tick and blink enable

    logic ms_tick; // one-cycle pulse per millisecond
    pdw_tick #(.CYC(TICK_CYC)) pdw_tick_inst (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tick_q(ms_tick)
    );

    logic [15:0] blink_cnt_q; // ms within a blink half period
    logic blink_q; // flash phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            blink_cnt_q <= 16'h0000;
            blink_q <= 1'b0;
        end else if (ms_tick) begin
            if (blink_cnt_q == 16'(BLINK_MS - 1)) begin
                blink_cnt_q <= 16'h0000;
                blink_q <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration

    // timeout: zero at reset, bad values refused and flagged
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tmo_q <= pdw_pkg::TMO_RST;
            tmo_err_q <= 1'b0;
        end else begin
            tmo_err_q <= 1'b0;
            if (tmo_wr) begin
                if (tmo_ok(tmo_wr_data)) tmo_q <= tmo_wr_data;
                else tmo_err_q <= 1'b1;
            end
        end
    end

    // substitute mode: unknown codes are ignored
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sub_mode_q <= pdw_pkg::SUB_ZERO;
        end else if (sub_wr && (sub_wr_data == pdw_pkg::SUB_ZERO ||
                     sub_wr_data == pdw_pkg::SUB_ONE ||
                     sub_wr_data == pdw_pkg::SUB_HOLD)) begin
            sub_mode_q <= sub_wr_data;
        end
    end

    // command decode
    logic cmd_valid; // one bit set
    logic cmd_set; // force fail
    logic cmd_ack; // acknowledge
    assign cmd_valid = cmd_wr && one_hot16(cmd_wr_data);
    assign cmd_set = cmd_valid && cmd_wr_data == pdw_pkg::CMD_SET_FAIL;
    assign cmd_ack = cmd_valid && cmd_wr_data == pdw_pkg::CMD_ACK_FAIL;

    // error answer pulse for multi-bit commands
    always_ff @(posedge sys_clk) begin
        if (sys_rst) cmd_err_q <= 1'b0;
        else cmd_err_q <= cmd_wr && !one_hot16(cmd_wr_data);
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog state machine

    pdw_pkg::pdw_wd_state_t st_q; // watchdog state
    logic [15:0] cnt_q; // ms elapsed since last restart
    logic [15:0] run_tmo_q; // timeout latched at restart
    logic ack_any; // acknowledgment this cycle
    logic expire; // watchdog ran out
    logic fail_in; // any failure source

    // auto mode takes a write; manual takes command or web page
    assign ack_any = manual_ack_mode ? (cmd_ack || web_ack)
                                     : out_wr;
    assign expire = (st_q == pdw_pkg::WD_RUN) && ms_tick &&
                    (cnt_q + 16'h0001 >= run_tmo_q);
    assign fail_in = expire || conn_timeout || cmd_set;

    // writes only; reads deliberately unused here
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= pdw_pkg::WD_IDLE;
            cnt_q <= 16'h0000;
            run_tmo_q <= 16'h0000;
        end else begin
            case (st_q)
                pdw_pkg::WD_IDLE: begin
                    // enabling a non-zero timeout arms it
                    if (tmo_q != 16'h0000) st_q <= pdw_pkg::WD_ARMED;
                end
                pdw_pkg::WD_ARMED: begin
                    // not yet started, so a zero timeout still disarms
                    if (tmo_q == 16'h0000) begin
                        st_q <= pdw_pkg::WD_IDLE;
                    end else if (out_wr) begin
                        st_q <= pdw_pkg::WD_RUN;
                        cnt_q <= 16'h0000;
                        run_tmo_q <= tmo_q;
                    end
                end
                pdw_pkg::WD_RUN: begin
                    // once running it is never stopped, even by tmo=0
                    if (expire) begin
                        st_q <= pdw_pkg::WD_FAIL;
                    end else if (out_wr) begin
                        cnt_q <= 16'h0000;
                        // zero cannot stop it, so the old timeout stays
                        if (tmo_q != 16'h0000) run_tmo_q <= tmo_q;
                    end else if (ms_tick) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                pdw_pkg::WD_FAIL: begin
                    // stays failed until acknowledged, then restarts
                    if (ack_any && !fail_in) begin
                        st_q <= pdw_pkg::WD_RUN;
                        cnt_q <= 16'h0000;
                        // a zero written meanwhile must not shorten it
                        if (tmo_q != 16'h0000) run_tmo_q <= tmo_q;
                    end
                end
                default: st_q <= pdw_pkg::WD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // communication-loss state, reason, status

    // new failure beats an acknowledge in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            net_fail_q <= 1'b0;
            fail_reason_q <= pdw_pkg::RSN_NONE;
        end else if (fail_in) begin
            net_fail_q <= 1'b1;
            if (expire) fail_reason_q <= pdw_pkg::RSN_WDOG;
            else if (conn_timeout) fail_reason_q <= pdw_pkg::RSN_CONN;
            else fail_reason_q <= pdw_pkg::RSN_USER;
        end else if (net_fail_q && ack_any) begin
            net_fail_q <= 1'b0;
        end
    end

    // status word: bit 1 mirrors the loss state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_q <= 16'h0000;
        end else begin
            status_q <= 16'h0000;
            status_q[pdw_pkg::STAT_FAIL_BIT] <= fail_in ||
                (net_fail_q && !ack_any);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output data path

    // storage keeps taking writes even while failed
    always_ff @(posedge sys_clk) begin
        if (sys_rst) out_store_q <= '0;
        else if (out_wr) out_store_q <= out_wr_data;
    end

    // loss state blocks stored data, drives substitutes
    logic fail_next; // loss state as of next cycle
    assign fail_next = fail_in || (net_fail_q && !ack_any);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_drive_q <= '0;
        end else if (fail_next) begin
            case (sub_mode_q)
                pdw_pkg::SUB_ONE: out_drive_q <= '1;
                pdw_pkg::SUB_HOLD: out_drive_q <= out_drive_q;
                default: out_drive_q <= '0;
            endcase
        end else if (out_wr) begin
            out_drive_q <= out_wr_data;
        end else begin
            out_drive_q <= out_store_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lamps

    // network lamp priority: red, steady yellow, flash, green
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            net_lamp_q <= pdw_pkg::LAMP_OFF;
        end else if (fail_next || s_dup) begin
            net_lamp_q <= pdw_pkg::LAMP_RED;
        end else if (s_ipbad) begin
            net_lamp_q <= pdw_pkg::LAMP_YELLOW;
        end else if (s_addr) begin
            net_lamp_q <= blink_q ? pdw_pkg::LAMP_YELLOW
                                  : pdw_pkg::LAMP_OFF;
        end else if (s_conn) begin
            net_lamp_q <= pdw_pkg::LAMP_GREEN;
        end else begin
            net_lamp_q <= pdw_pkg::LAMP_OFF;
        end
    end

    // supply lamps, overload wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sensor_supply_lamp_q <= pdw_pkg::LAMP_OFF;
            actuator_supply_lamp_q <= 1'b0;
        end else begin
            if (s_sovl) sensor_supply_lamp_q <= pdw_pkg::LAMP_RED;
            else if (s_sens) sensor_supply_lamp_q <= pdw_pkg::LAMP_GREEN;
            else sensor_supply_lamp_q <= pdw_pkg::LAMP_OFF;
            actuator_supply_lamp_q <= s_act;
        end
    end

    // channel lamps show the real drive, not stored data
    pdw_lamps #(.NCH(NCH)) pdw_lamps_inst (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_state(s_in),
        .out_state(out_drive_q),
        .out_fault(s_oflt),
        .in_lamp_q(in_lamp_q),
        .out_lamp_q(out_lamp_q)
    );

    ////////////////////////////////////////////////////////////////////
    // assertions

    property p_wd_expiry_fail;
        @(posedge sys_clk) disable iff (sys_rst)
        expire |=> net_fail_q && fail_reason_q == pdw_pkg::RSN_WDOG;
    endproperty
    a_wd_expiry_fail: assert property (p_wd_expiry_fail)
        else $error("expiry did not set loss state");

    property p_status_bit;
        @(posedge sys_clk) disable iff (sys_rst)
        ##1 status_q[1] == net_fail_q;
    endproperty
    a_status_bit: assert property (p_status_bit)
        else $error("status bit differs from loss state");

    property p_read_no_restart;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_q == pdw_pkg::WD_RUN && out_rd && !out_wr && !ms_tick
         && !expire) |=> cnt_q == $past(cnt_q);
    endproperty
    a_read_no_restart: assert property (p_read_no_restart)
        else $error("read changed watchdog count");

    property p_no_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        st_q == pdw_pkg::WD_RUN |=> st_q != pdw_pkg::WD_IDLE;
    endproperty
    a_no_stop: assert property (p_no_stop)
        else $error("running watchdog stopped");

    property p_sub_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        (fail_next && sub_mode_q == pdw_pkg::SUB_ZERO) |=> out_drive_q == '0;
    endproperty
    a_sub_zero: assert property (p_sub_zero)
        else $error("substitute zero not applied");

    property p_hold_until_ack;
        @(posedge sys_clk) disable iff (sys_rst)
        (net_fail_q && !ack_any) |=> net_fail_q;
    endproperty
    a_hold_until_ack: assert property (p_hold_until_ack)
        else $error("loss cleared without acknowledge");

    property p_ack_restart;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_q == pdw_pkg::WD_FAIL && ack_any && !fail_in) |=>
        st_q == pdw_pkg::WD_RUN && cnt_q == 16'h0000;
    endproperty
    a_ack_restart: assert property (p_ack_restart)
        else $error("acknowledge did not restart watchdog");

    property p_tmo_range;
        @(posedge sys_clk) disable iff (sys_rst)
        (tmo_wr && !tmo_ok(tmo_wr_data)) |=> tmo_q == $past(tmo_q)
        && tmo_err_q;
    endproperty
    a_tmo_range: assert property (p_tmo_range)
        else $error("bad timeout accepted");

    property p_cmd_err;
        @(posedge sys_clk) disable iff (sys_rst)
        (cmd_wr && cmd_wr_data == 16'h0030) |=> cmd_err_q;
    endproperty
    a_cmd_err: assert property (p_cmd_err)
        else $error("multi-bit command not refused");

    property p_manual_ack;
        @(posedge sys_clk) disable iff (sys_rst)
        (manual_ack_mode && net_fail_q && out_wr && !cmd_ack && !web_ack)
        |=> net_fail_q;
    endproperty
    a_manual_ack: assert property (p_manual_ack)
        else $error("write acknowledged in manual mode");

    c_expire: cover property (@(posedge sys_clk) expire);
    c_auto_ack: cover property (@(posedge sys_clk)
        net_fail_q && !manual_ack_mode ##1 !net_fail_q);
    c_cmd_ack: cover property (@(posedge sys_clk) cmd_ack && net_fail_q);
endmodule

// [verif/pdw_client.sv]
// Purpose: client model that writes and reads process data
// Assumes: requests start on a falling edge, one cycle each
// Notes: idle data lines carry the inverse of the last value
`timescale 1ns/1ps
module pdw_client (
    input wire logic sys_clk,
    output logic out_wr,
    output logic [7:0] out_wr_data,
    output logic out_rd,
    output logic tmo_wr,
    output logic [15:0] tmo_wr_data,
    output logic sub_wr,
    output logic [15:0] sub_wr_data,
    output logic cmd_wr,
    output logic [15:0] cmd_wr_data
);
    logic [4:0] stb = 5'h00; // strobes: out, rd, tmo, sub, cmd
    logic [15:0] wdata = 16'h0000; // one data bus shared by all writes
    assign {cmd_wr, sub_wr, tmo_wr, out_rd, out_wr} = stb;
    assign out_wr_data = wdata[7:0];
    assign tmo_wr_data = wdata;
    assign sub_wr_data = wdata;
    assign cmd_wr_data = wdata;
    ////////////////////////////////////////////////////////////
    // one request per call; caller picks values and spacing
    task automatic req(input int unsigned k, input logic [15:0] d);
        @(negedge sys_clk);
        wdata = d;
        stb[k] = 1'b1;
        @(negedge sys_clk);
        stb = 5'h00;
        wdata = ~d; // a released bus must not look still valid
    endtask
endmodule

// [verif/process_data_watchdog_netfail_bench.sv]
// Purpose: self-checking bench for the supervision block
// Assumes: tick cut to 10 cycles, blink half period to 2 ms
// Notes: inputs change and outputs are read on the falling edge
`timescale 1ns/1ps
module process_data_watchdog_netfail_bench;
    localparam int unsigned W_OUT = 0;
    localparam int unsigned W_RD = 1;
    localparam int unsigned W_TMO = 2;
    localparam int unsigned W_SUB = 3;
    localparam int unsigned W_CMD = 4;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic out_wr, out_rd, tmo_wr, sub_wr, cmd_wr;
    logic [7:0] out_wr_data;
    logic [15:0] tmo_wr_data, sub_wr_data, cmd_wr_data;
    logic [1:0] pv = 2'h0; // web acknowledge, connection timeout
    logic manual_ack_mode = 1'b0, conn_up = 1'b0, act_ok = 1'b0;
    logic addr_req_active = 1'b0, ip_invalid = 1'b0;
    logic static_dup_ip = 1'b0, sens_ok = 1'b0, sens_overload = 1'b0;
    logic [7:0] in_pins = 8'h00, out_fault_pins = 8'h00;
    logic [7:0] out_drive_q, out_store_q, in_lamp_q;
    logic [15:0] tmo_q, sub_mode_q, fail_reason_q, status_q, out_lamp_q;
    logic net_fail_q, cmd_err_q, tmo_err_q, actuator_supply_lamp_q;
    logic [1:0] net_lamp_q, sensor_supply_lamp_q;
    int unsigned mismatches = 0, checks_done = 0;
    ////////////////////////////////////////////////////////////
    pdw_top #(.TICK_CYC(10), .BLINK_MS(2)) pdw_top_inst (
        .web_ack(pv[0]),
        .conn_timeout(pv[1]),
        .*
    );
    pdw_client pdw_client_inst (.*);
    // free running 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic settle(input int unsigned n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic req(input int unsigned k, input logic [15:0] d);
        pdw_client_inst.req(k, d);
    endtask
    task automatic pulse(input int unsigned k);
        @(negedge sys_clk);
        pv[k] = 1'b1;
        @(negedge sys_clk);
        pv = 2'h0;
    endtask
    // bounded wait; a lapse ends the run
    task automatic wait_fail(input int unsigned n);
        repeat (n) begin
            if (net_fail_q !== 1'b1) @(negedge sys_clk);
        end
        check(16'(net_fail_q), 16'h0001);
        if (net_fail_q !== 1'b1) summarize();
    endtask
    // reads only during the wait, so expiry must still come on time
    task automatic t_expire(input logic [15:0] code, input logic [7:0] d,
            input logic [7:0] sb);
        logic [7:0] nd;
        nd = ~d;
        req(W_SUB, code);
        check(sub_mode_q, code);
        req(W_OUT, 16'(d));
        check(16'(out_drive_q), 16'(d));
        repeat (189) begin
            req(W_RD, 16'h0000);
            settle(8);
        end
        check(16'(net_fail_q), 16'h0000);
        wait_fail(400);
        check(fail_reason_q, pdw_pkg::RSN_WDOG);
        check(16'(status_q[1]), 16'h0001);
        check(16'(net_lamp_q), 16'(pdw_pkg::LAMP_RED));
        check(16'(out_drive_q), 16'(sb));
        req(W_OUT, 16'(nd));
        check(16'(net_fail_q), 16'h0000);
        check(16'(out_drive_q), 16'(nd));
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        int unsigned n;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        check(tmo_q, 16'h0000);
        req(W_TMO, 16'h00C7);
        check(16'(tmo_err_q), 16'h0001);
        req(W_TMO, 16'hFDE9);
        check(tmo_q, 16'h0000);
        req(W_TMO, 16'h00C8);
        check(tmo_q, 16'h00C8);
        t_expire(pdw_pkg::SUB_ZERO, 8'hA5, 8'h00);
        t_expire(pdw_pkg::SUB_ONE, 8'h5A, 8'hFF);
        t_expire(pdw_pkg::SUB_HOLD, 8'hC3, 8'hC3);
        manual_ack_mode = 1'b1;
        req(W_TMO, 16'h0000);
        wait_fail(2100);
        req(W_OUT, 16'h0081);
        check(16'(out_store_q), 16'h0081);
        check(16'(out_drive_q), 16'h003C);
        req(W_CMD, 16'h0030);
        check(16'(cmd_err_q), 16'h0001);
        check(16'(net_fail_q), 16'h0001);
        req(W_CMD, pdw_pkg::CMD_ACK_FAIL);
        check(16'(out_drive_q), 16'h0081);
        req(W_CMD, pdw_pkg::CMD_SET_FAIL);
        check(fail_reason_q, pdw_pkg::RSN_USER);
        pulse(0);
        check(16'(net_fail_q), 16'h0000);
        pulse(1);
        check(fail_reason_q, pdw_pkg::RSN_CONN);
        pulse(0);
        conn_up = 1'b1;
        sens_ok = 1'b1;
        act_ok = 1'b1;
        in_pins = 8'h81;
        out_fault_pins = 8'h02;
        settle(5);
        check(16'(net_lamp_q), 16'(pdw_pkg::LAMP_GREEN));
        check(16'(sensor_supply_lamp_q), 16'h0001);
        check(16'(actuator_supply_lamp_q), 16'h0001);
        check(16'(in_lamp_q), 16'h0081);
        check(out_lamp_q, 16'h800E);
        addr_req_active = 1'b1;
        n = 0;
        repeat (80) begin
            settle(1);
            n += 32'(net_lamp_q === pdw_pkg::LAMP_YELLOW);
        end
        check(16'(n > 0 && n < 80), 16'h0001);
        ip_invalid = 1'b1;
        settle(5);
        check(16'(net_lamp_q), 16'(pdw_pkg::LAMP_YELLOW));
        static_dup_ip = 1'b1;
        settle(5);
        check(16'(net_lamp_q), 16'(pdw_pkg::LAMP_RED));
        sens_overload = 1'b1;
        settle(5);
        check(16'(sensor_supply_lamp_q), 16'h0003);
        sens_ok = 1'b0;
        sens_overload = 1'b0;
        act_ok = 1'b0;
        settle(5);
        check(16'(sensor_supply_lamp_q), 16'h0000);
        check(16'(actuator_supply_lamp_q), 16'h0000);
        summarize();
    end
endmodule
